// ---- core/pgr_pkg.sv ----
// Constants, field layouts and carrier types of the power gating and reset block.
// Assumes one 100 MHz clock and a synchronous, active-high reset.
package pgr_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] PGR_ADDR_PRIMARY = 8'h00;
   localparam logic [7:0] PGR_ADDR_STROBE = 8'h01;
   localparam logic [7:0] PGR_ADDR_STATUS = 8'h02;
   localparam logic [7:0] PGR_REG_RESET = 8'h00;
   localparam logic [7:0] PGR_PRIMARY_MASK = 8'h3a;
   localparam logic [7:0] PGR_STROBE_MASK = 8'h3c;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int PGR_POWER_DOWN_ENABLE_BIT = 1;
   localparam int PGR_FULL_SPEED_BIT = 3;
   localparam int PGR_ARRAY_CLOCK_GATE_BIT = 4;
   localparam int PGR_MACROCELL_CLOCK_GATE_BIT = 5;
   localparam int PGR_WR_GATE_BIT = 2;
   localparam int PGR_RD_GATE_BIT = 3;
   localparam int PGR_PROG_STORE_GATE_BIT = 4;
   localparam int PGR_ALE_GATE_BIT = 5;
   localparam int PGR_STATUS_FLAG_BIT = 0;
   localparam int PGR_STATUS_LOADED_BIT = 1;
   localparam int PGR_STATUS_READY_BIT = 2;
   localparam int PGR_STATUS_RESET_BIT = 3;
   localparam int PGR_STATUS_COUNT_LSB = 4;

   // ****************************************
   // Timing
   // ****************************************
   localparam int PGR_IDLE_WIDTH = 4;
   localparam int PGR_IDLE_LIMIT = 15;
   localparam int PGR_CLOCK_MHZ = 100;
   localparam int PGR_OPR_DELAY_NS = 200;
   localparam int PGR_CONFIG_LOAD_NS = 100;
   localparam int PGR_OPR_CYCLES = (PGR_OPR_DELAY_NS * PGR_CLOCK_MHZ + 999) / 1000;
   localparam int PGR_CONFIG_CYCLES = (PGR_CONFIG_LOAD_NS * PGR_CLOCK_MHZ + 999) / 1000;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [3:0] {
      PGR_CONFIG = 4'h1,
      PGR_HOLD = 4'h2,
      PGR_SETTLE = 4'h4,
      PGR_RUN = 4'h8
   } pgr_state_e;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } pgr_bus_s;

   typedef struct packed {
      logic wr_n;
      logic rd_n;
      logic program_store_enable_n;
      logic ale;
   } pgr_host_s;

   typedef struct packed {
      logic flash_en;
      logic sram_en;
      logic io_en;
      logic ready;
   } pgr_mem_s;

endpackage

// ---- core/pgr_signal_gate.sv ----
// One blocking gate between a host signal and the logic array.
// Assumes the input is synchronous to the clock.
module pgr_signal_gate #(
   parameter logic IDLE = 1'b0
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   input wire logic clk_en,
   // Gate
   input wire logic block,
   input wire logic sig_in,
   output logic sig_out
);

   typedef struct packed {
      logic out;
   } pgr_gate_s;

   pgr_gate_s st_reg;
   pgr_gate_s st_next;

   // ****************************************
   // Gate
   // ****************************************
   always_comb begin
      st_next = st_reg;
      if (clk_en) begin
         // Blocked input parks at its idle level so the array sees no toggles
         st_next.out = block ? IDLE : sig_in;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_reg <= '{out: IDLE};
      end else begin
         st_reg <= st_next;
      end
   end

   assign sig_out = st_reg.out;

endmodule

// ---- core/pgr_idle_counter.sv ----
// Idle counter that raises the power-down flag after a run of quiet clocks.
// Assumes tick and activity are one-cycle pulses from the parent.
module pgr_idle_counter #(
   parameter int WIDTH = pgr_pkg::PGR_IDLE_WIDTH,
   parameter int LIMIT = pgr_pkg::PGR_IDLE_LIMIT
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   input wire logic clk_en,
   // Control
   input wire logic enable,
   input wire logic tick,
   input wire logic activity,
   input wire logic wake,
   // Result
   output logic [WIDTH-1:0] count,
   output logic flag
);

   initial begin
      if (LIMIT < 1 || LIMIT >= (1 << WIDTH)) begin
         $error("pgr_idle_counter: LIMIT does not fit WIDTH");
      end
   end

   localparam logic [WIDTH-1:0] LIMIT_V = WIDTH'(LIMIT);

   typedef struct packed {
      logic [WIDTH-1:0] cnt;
      logic flag;
   } pgr_idle_s;

   pgr_idle_s st_reg;
   pgr_idle_s st_next;

   // ****************************************
   // Counting
   // ****************************************
   always_comb begin
      st_next = st_reg;
      if (clk_en) begin
         if (!enable || activity || wake) begin
            st_next.cnt = '0;
            st_next.flag = 1'b0;
         end else if (tick && st_reg.cnt != LIMIT_V) begin
            st_next.cnt = st_reg.cnt + WIDTH'(1);
            st_next.flag = (st_reg.cnt + WIDTH'(1)) == LIMIT_V;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_reg <= '{cnt: '0, flag: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign count = st_reg.cnt;
   assign flag = st_reg.flag;

endmodule

// ---- core/pgr_power_ctrl.sv ----
// Power gating, idle power-down and reset sequencing of the peripheral module.
// Assumes all pins are synchronous to clock; rst is the power-on reset.
module pgr_power_ctrl #(
   parameter int OPR_CYCLES = pgr_pkg::PGR_OPR_CYCLES,
   parameter int CONFIG_CYCLES = pgr_pkg::PGR_CONFIG_CYCLES,
   parameter int BUS_WIDTH = 8
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   input wire logic clk_en,
   // Register port
   input wire pgr_pkg::pgr_bus_s reg_bus,
   output logic [7:0] reg_rdata,
   // Host pins
   input wire logic reset_n_pin,
   input wire logic port_d_pin_two,
   input wire logic port_d_pin_one,
   input wire pgr_pkg::pgr_host_s host,
   input wire logic [BUS_WIDTH-1:0] host_bus,
   // Memory side
   output pgr_pkg::pgr_mem_s mem,
   output logic flash_read_cmd,
   output logic [BUS_WIDTH-1:0] mem_bus,
   // Logic array side
   output logic [BUS_WIDTH-1:0] logic_bus,
   output logic array_clock,
   output logic macrocell_clock,
   output pgr_pkg::pgr_host_s array_strobes,
   output logic logic_wake,
   output logic low_power_mode,
   output logic logic_outputs_valid,
   // Status
   output logic power_down_flag,
   output logic in_reset
);

   initial begin
      if (OPR_CYCLES < 1 || OPR_CYCLES > 65535) begin
         $error("pgr_power_ctrl: OPR_CYCLES out of range");
      end
      if (CONFIG_CYCLES < 1 || CONFIG_CYCLES > 65535) begin
         $error("pgr_power_ctrl: CONFIG_CYCLES out of range");
      end
      if (BUS_WIDTH < 1) begin
         $error("pgr_power_ctrl: BUS_WIDTH must be positive");
      end
   end

   localparam logic [15:0] OPR_LAST = 16'(OPR_CYCLES - 1);
   localparam logic [15:0] CONFIG_LAST = 16'(CONFIG_CYCLES - 1);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      pgr_pkg::pgr_state_e fsm;
      logic [15:0] timer;
      logic [7:0] primary;
      logic [7:0] strobe;
      logic [7:0] rdata;
      logic clk_prev;
      logic ale_prev;
      logic loaded;
      pgr_pkg::pgr_mem_s mem;
      logic flash_read;
      logic [BUS_WIDTH-1:0] mem_bus;
      logic [BUS_WIDTH-1:0] logic_bus;
      logic wake;
      logic low_power;
      logic in_reset;
   } pgr_ctrl_s;

   pgr_ctrl_s st_reg;
   pgr_ctrl_s st_next;

   logic idle_flag;
   logic [pgr_pkg::PGR_IDLE_WIDTH-1:0] idle_count;
   logic clk_tick;
   logic ale_activity;
   logic reset_asserted;
   logic selected;
   logic running;
   logic accept;
   logic [5:0] block_vec;
   logic [5:0] gate_in;
   logic [5:0] gate_out;

   // ****************************************
   // Pin events
   // ****************************************
   always_comb begin
      clk_tick = port_d_pin_one && !st_reg.clk_prev;
      ale_activity = host.ale != st_reg.ale_prev;
      reset_asserted = !reset_n_pin;
      selected = !port_d_pin_two;
      running = st_reg.fsm == pgr_pkg::PGR_RUN;
      // Register port answers only to a selected, running device
      accept = running && selected;
   end

   // ****************************************
   // Idle power-down counter
   // ****************************************
   pgr_idle_counter #(
      .WIDTH(pgr_pkg::PGR_IDLE_WIDTH),
      .LIMIT(pgr_pkg::PGR_IDLE_LIMIT)
   ) u_idle (
      .clock(clock),
      .rst(rst),
      .clk_en(clk_en),
      .enable(st_reg.primary[pgr_pkg::PGR_POWER_DOWN_ENABLE_BIT]),
      .tick(clk_tick),
      .activity(ale_activity),
      .wake(selected || reset_asserted),
      .count(idle_count),
      .flag(idle_flag)
   );

   // ****************************************
   // Signal blocking toward the logic array
   // ****************************************
   always_comb begin
      block_vec = '0;
      block_vec[0] = st_reg.primary[pgr_pkg::PGR_ARRAY_CLOCK_GATE_BIT];
      block_vec[1] = st_reg.primary[pgr_pkg::PGR_MACROCELL_CLOCK_GATE_BIT];
      block_vec[2] = st_reg.strobe[pgr_pkg::PGR_WR_GATE_BIT];
      block_vec[3] = st_reg.strobe[pgr_pkg::PGR_RD_GATE_BIT];
      block_vec[4] = st_reg.strobe[pgr_pkg::PGR_PROG_STORE_GATE_BIT];
      block_vec[5] = st_reg.strobe[pgr_pkg::PGR_ALE_GATE_BIT];
      gate_in = {host.ale, host.program_store_enable_n, host.rd_n, host.wr_n, port_d_pin_one,
         port_d_pin_one};
   end

   // Blocked strobes park inactive: active-low ones high, latch strobe low
   localparam logic [5:0] GATE_IDLE = 6'h1c;

   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_gate
         pgr_signal_gate #(
            .IDLE(GATE_IDLE[gi])
         ) u_gate (
            .clock(clock),
            .rst(rst),
            .clk_en(clk_en),
            .block(block_vec[gi]),
            .sig_in(gate_in[gi]),
            .sig_out(gate_out[gi])
         );
      end
   endgenerate

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      st_next = st_reg;
      if (clk_en) begin
         st_next.clk_prev = port_d_pin_one;
         st_next.ale_prev = host.ale;
         st_next.rdata = 8'h00;

         // Reset sequencing
         unique case (st_reg.fsm)
            pgr_pkg::PGR_CONFIG: begin
               if (st_reg.timer == CONFIG_LAST) begin
                  st_next.loaded = 1'b1;
                  st_next.timer = 16'h0000;
                  st_next.fsm = reset_asserted ? pgr_pkg::PGR_HOLD : pgr_pkg::PGR_SETTLE;
               end else begin
                  st_next.timer = st_reg.timer + 16'h0001;
               end
            end
            pgr_pkg::PGR_HOLD: begin
               st_next.timer = 16'h0000;
               if (!reset_asserted) begin
                  st_next.fsm = pgr_pkg::PGR_SETTLE;
               end
            end
            pgr_pkg::PGR_SETTLE: begin
               if (reset_asserted) begin
                  st_next.fsm = pgr_pkg::PGR_HOLD;
                  st_next.timer = 16'h0000;
               end else if (st_reg.timer == OPR_LAST) begin
                  st_next.fsm = pgr_pkg::PGR_RUN;
                  st_next.timer = 16'h0000;
               end else begin
                  st_next.timer = st_reg.timer + 16'h0001;
               end
            end
            pgr_pkg::PGR_RUN: begin
               if (reset_asserted) begin
                  // One sampled cycle is enough for a warm reset
                  st_next.fsm = pgr_pkg::PGR_HOLD;
               end
            end
            default: begin
               st_next.fsm = pgr_pkg::PGR_CONFIG;
               st_next.timer = 16'h0000;
            end
         endcase

         // Flash forced to read mode for as long as any reset lasts
         st_next.flash_read = st_next.fsm != pgr_pkg::PGR_RUN;
         st_next.in_reset = st_next.fsm != pgr_pkg::PGR_RUN;

         // Register writes; power registers survive warm resets
         if (accept && reg_bus.wr) begin
            unique case (reg_bus.addr)
               pgr_pkg::PGR_ADDR_PRIMARY: begin
                  st_next.primary = reg_bus.wdata & pgr_pkg::PGR_PRIMARY_MASK;
               end
               pgr_pkg::PGR_ADDR_STROBE: begin
                  st_next.strobe = reg_bus.wdata & pgr_pkg::PGR_STROBE_MASK;
               end
               default: begin
               end
            endcase
         end

         // Register reads, answered in the next cycle only
         if (accept && reg_bus.rd) begin
            unique case (reg_bus.addr)
               pgr_pkg::PGR_ADDR_PRIMARY: begin
                  st_next.rdata = st_reg.primary;
               end
               pgr_pkg::PGR_ADDR_STROBE: begin
                  st_next.rdata = st_reg.strobe;
               end
               pgr_pkg::PGR_ADDR_STATUS: begin
                  st_next.rdata[pgr_pkg::PGR_STATUS_FLAG_BIT] = idle_flag;
                  st_next.rdata[pgr_pkg::PGR_STATUS_LOADED_BIT] = st_reg.loaded;
                  st_next.rdata[pgr_pkg::PGR_STATUS_READY_BIT] = st_reg.mem.ready;
                  st_next.rdata[pgr_pkg::PGR_STATUS_RESET_BIT] = st_reg.in_reset;
                  st_next.rdata[pgr_pkg::PGR_STATUS_COUNT_LSB +: pgr_pkg::PGR_IDLE_WIDTH] =
                     idle_count;
               end
               default: begin
                  st_next.rdata = 8'h00;
               end
            endcase
         end

         // Memory selection; logic keeps running whatever the select does
         st_next.mem.ready = running;
         st_next.mem.io_en = running && selected;
         st_next.mem.flash_en = running && selected && !idle_flag;
         st_next.mem.sram_en = running && selected && !idle_flag;

         // Bus blocking during power-down
         st_next.mem_bus = (idle_flag || !running) ? '0 : host_bus;
         st_next.logic_bus = idle_flag ? '0 : host_bus;

         // Speed mode and wake-up of the array
         st_next.low_power = st_reg.primary[pgr_pkg::PGR_FULL_SPEED_BIT];
         st_next.wake = clk_tick && !st_reg.primary[pgr_pkg::PGR_ARRAY_CLOCK_GATE_BIT]
            && !st_reg.primary[pgr_pkg::PGR_FULL_SPEED_BIT];
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         st_reg.fsm <= pgr_pkg::PGR_CONFIG;
         st_reg.timer <= 16'h0000;
         st_reg.primary <= pgr_pkg::PGR_REG_RESET;
         st_reg.strobe <= pgr_pkg::PGR_REG_RESET;
         st_reg.rdata <= 8'h00;
         st_reg.clk_prev <= 1'b0;
         st_reg.ale_prev <= 1'b0;
         st_reg.loaded <= 1'b0;
         st_reg.mem <= '0;
         st_reg.flash_read <= 1'b1;
         st_reg.mem_bus <= '0;
         st_reg.logic_bus <= '0;
         st_reg.wake <= 1'b0;
         st_reg.low_power <= 1'b0;
         st_reg.in_reset <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign reg_rdata = st_reg.rdata;
   assign mem = st_reg.mem;
   assign flash_read_cmd = st_reg.flash_read;
   assign mem_bus = st_reg.mem_bus;
   assign logic_bus = st_reg.logic_bus;
   assign array_clock = gate_out[0];
   assign macrocell_clock = gate_out[1];
   assign array_strobes = '{wr_n: gate_out[2], rd_n: gate_out[3],
                            program_store_enable_n: gate_out[4], ale: gate_out[5]};
   assign logic_wake = st_reg.wake;
   assign low_power_mode = st_reg.low_power;
   // Loaded once at power-on and kept through warm resets
   assign logic_outputs_valid = st_reg.loaded;
   assign power_down_flag = idle_flag;
   assign in_reset = st_reg.in_reset;

endmodule

// ---- sim/pgr_power_ctrl_chk.sv ----
// Checker of the power gating and reset block, bound to its top module.
// Assumes one clock and a synchronous, active-high power-on reset.
module pgr_power_ctrl_chk #(
   parameter int OPR_CYCLES = pgr_pkg::PGR_OPR_CYCLES,
   parameter int BUS_WIDTH = 8
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Pins
   input wire logic reset_n_pin,
   input wire logic port_d_pin_two,
   input wire logic port_d_pin_one,
   input wire pgr_pkg::pgr_host_s host,
   input wire logic [BUS_WIDTH-1:0] host_bus,
   // Results
   input wire pgr_pkg::pgr_mem_s mem,
   input wire logic flash_read_cmd,
   input wire logic [BUS_WIDTH-1:0] mem_bus,
   input wire logic [BUS_WIDTH-1:0] logic_bus,
   input wire logic logic_outputs_valid,
   input wire logic power_down_flag,
   input wire logic in_reset
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // Helper counters
   // ****************************************
   // Tick count overcounts when enable is off, so only a lower bound is safe
   logic [4:0] tk;
   logic [7:0] rc;
   logic pin_q;
   logic ale_q;
   always_ff @(posedge clock) begin
      pin_q <= port_d_pin_one;
      ale_q <= host.ale;
      if (rst || !port_d_pin_two || !reset_n_pin || host.ale != ale_q) begin
         tk <= '0;
      end else if (port_d_pin_one && !pin_q && tk != 5'h1f) begin
         tk <= tk + 5'h01;
      end
      if (rst || !reset_n_pin) begin
         rc <= '0;
      end else if (in_reset && rc != 8'hff) begin
         rc <= rc + 8'h01;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   a_cs_low_io: assert property ((!port_d_pin_two && reset_n_pin && !in_reset) |=> mem.io_en)
      else $error("io block not enabled while selected");
   a_cs_high_mem: assert property (port_d_pin_two |=> !mem.flash_en && !mem.sram_en)
      else $error("memory enabled while deselected");
   a_logic_live: assert property ((port_d_pin_two && !power_down_flag) |=> logic_bus == $past(host_bus))
      else $error("logic bus stopped while deselected");
   a_pd_ticks: assert property ($rose(power_down_flag) |-> tk >= 5'd15)
      else $error("power-down flag before fifteen quiet ticks");
   a_ready_delay: assert property ($fell(in_reset) |-> rc > OPR_CYCLES)
      else $error("reset left before ready delay");
   a_reset_start: assert property ($fell(rst) |-> in_reset && flash_read_cmd && !mem.ready)
      else $error("wrong state after power-on reset");
   a_warm_hold: assert property (!reset_n_pin |=> in_reset && flash_read_cmd)
      else $error("warm reset not taken");
   a_valid_kept: assert property (logic_outputs_valid |=> logic_outputs_valid)
      else $error("logic outputs lost validity");
   a_pd_wake: assert property ((!port_d_pin_two || !reset_n_pin || $changed(host.ale)) |-> ##[1:2] !power_down_flag)
      else $error("power-down not left on wake cause");
   a_pd_blocks: assert property (power_down_flag |=> mem_bus == '0 && logic_bus == '0 && !mem.flash_en)
      else $error("bus reached memory in power-down");
endmodule

// ---- sim/pgr_host_model.sv ----
// Host core model: host strobes, latch strobe and address/data.
// Assumes busy from the bench; idle keeps strobes off and the latch strobe static.
module pgr_host_model (
   // Clock and control
   input wire logic clock,
   input wire logic rst,
   input wire logic busy,
   // Host side
   output pgr_pkg::pgr_host_s host,
   output logic [7:0] host_bus
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] ph = 3'h0;
   initial host = '{1'b1, 1'b1, 1'b1, 1'b0};
   initial host_bus = 8'h00;
   // Bus keeps changing so a stale copy never matches by luck
   always @(posedge clock) begin
      host_bus <= host_bus + 8'h3b;
      ph <= ph + 3'h1;
      if (rst) begin
         host <= '{1'b1, 1'b1, 1'b1, 1'b0};
      end else if (busy) begin
         host <= '{ph[0], ph[1], ph[2], ~host.ale};
      end else begin
         host <= '{1'b1, 1'b1, 1'b1, host.ale};
      end
   end
endmodule

// ---- sim/pgr_power_ctrl_tb.sv ----
// Self-checking bench of the power gating and reset block.
// Assumes the host model and checker are compiled first; 100 MHz clock.
module pgr_power_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int OPR = 4;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic clk_en = 1'b1;
   logic reset_n_pin = 1'b1;
   logic port_d_pin_two = 1'b0;
   logic port_d_pin_one = 1'b0;
   logic busy = 1'b0;
   logic rd_q = 1'b0;
   pgr_pkg::pgr_bus_s reg_bus = '0;
   pgr_pkg::pgr_host_s host, array_strobes, h;
   pgr_pkg::pgr_mem_s mem;
   logic [7:0] host_bus, reg_rdata, mem_bus, logic_bus, p, s;
   logic flash_read_cmd, array_clock, macrocell_clock, logic_wake, low_power_mode;
   logic logic_outputs_valid, power_down_flag, in_reset;
   logic [7:0] gv [4] = '{8'h10, 8'h20, 8'h08, 8'h00};
   logic [7:0] exp_q [$];
   int errors = 0;
   int n_checks = 0;

   always #5 clock = ~clock;

   pgr_power_ctrl #(.OPR_CYCLES(OPR), .CONFIG_CYCLES(2), .BUS_WIDTH(8)) dut_u (
      .clock(clock), .rst(rst), .clk_en(clk_en), .reg_bus(reg_bus), .reg_rdata(reg_rdata),
      .reset_n_pin(reset_n_pin), .port_d_pin_two(port_d_pin_two),
      .port_d_pin_one(port_d_pin_one), .host(host), .host_bus(host_bus), .mem(mem),
      .flash_read_cmd(flash_read_cmd), .mem_bus(mem_bus), .logic_bus(logic_bus),
      .array_clock(array_clock), .macrocell_clock(macrocell_clock),
      .array_strobes(array_strobes), .logic_wake(logic_wake), .low_power_mode(low_power_mode),
      .logic_outputs_valid(logic_outputs_valid), .power_down_flag(power_down_flag),
      .in_reset(in_reset));

   pgr_host_model host_u (.clock(clock), .rst(rst), .busy(busy), .host(host),
      .host_bus(host_bus));

   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      if (errors == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic at(input int n);
      repeat (n) @(posedge clock);
   endtask

   // Idle cycle after each strobe keeps one assignment per time step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_bus <= '{a, d, 1'b1, 1'b0};
      at(1);
      reg_bus <= '0;
      at(1);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      reg_bus <= '{a, 8'h00, 1'b0, 1'b1};
      at(1);
      reg_bus <= '0;
      at(1);
   endtask

   task automatic ready();
      repeat (100) if (mem.ready !== 1'b1) at(1);
      #1;
      chk(mem.ready, 1'b1);
      chk(logic_outputs_valid, 1'b1);
      at(1);
   endtask

   task automatic pulses(input int n);
      repeat (n) begin
         port_d_pin_one <= 1'b1;
         at(2);
         port_d_pin_one <= 1'b0;
         at(2);
      end
   endtask

   task automatic idle_run(input logic [7:0] pv, input int n, input logic f);
      // Register port answers only while selected
      port_d_pin_two <= 1'b0;
      wr(pgr_pkg::PGR_ADDR_PRIMARY, pv);
      port_d_pin_two <= 1'b1;
      pulses(n);
      #1;
      chk(power_down_flag, f);
      at(1);
   endtask

   // Read answers arrive one cycle after the strobe
   always @(posedge clock) begin
      if (rd_q) chk(reg_rdata, exp_q.pop_front());
      rd_q <= reg_bus.rd;
   end

   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      void'($urandom(32'h38f8));
      at(15);
      #1;
      chk(in_reset, 1'b1);
      chk(flash_read_cmd, 1'b1);
      at(1);
      rst <= 1'b0;
      ready();
      #1;
      chk(mem.flash_en, 1'b1);
      chk(mem.io_en, 1'b1);
      at(1);
      rd(pgr_pkg::PGR_ADDR_PRIMARY, 8'h00);
      rd(pgr_pkg::PGR_ADDR_STROBE, 8'h00);
      rd(8'h03, 8'h00);
      rd(pgr_pkg::PGR_ADDR_STATUS, 8'h06);
      repeat (4) begin
         p = 8'($urandom) & pgr_pkg::PGR_PRIMARY_MASK;
         s = 8'($urandom) & pgr_pkg::PGR_STROBE_MASK;
         wr(pgr_pkg::PGR_ADDR_PRIMARY, p);
         wr(pgr_pkg::PGR_ADDR_STROBE, s);
         rd(pgr_pkg::PGR_ADDR_PRIMARY, p);
         rd(pgr_pkg::PGR_ADDR_STROBE, s);
      end
      port_d_pin_two <= 1'b1;
      wr(pgr_pkg::PGR_ADDR_PRIMARY, 8'h3a);
      #1;
      chk(mem.flash_en | mem.sram_en, 1'b0);
      at(1);
      port_d_pin_two <= 1'b0;
      rd(pgr_pkg::PGR_ADDR_PRIMARY, p);
      foreach (gv[i]) begin
         wr(pgr_pkg::PGR_ADDR_PRIMARY, gv[i]);
         port_d_pin_one <= 1'b1;
         at(1);
         #1;
         chk(logic_wake, 8'(!gv[i][4] && !gv[i][3]));
         at(1);
         #1;
         chk(array_clock, !gv[i][4]);
         chk(macrocell_clock, !gv[i][5]);
         chk(low_power_mode, gv[i][3]);
         at(1);
         port_d_pin_one <= 1'b0;
      end
      busy <= 1'b1;
      for (int b = 2; b < 6; b++) begin
         wr(pgr_pkg::PGR_ADDR_STROBE, 8'h01 << b);
         repeat (3) begin
            h = host;
            h.wr_n |= (b == 2);
            h.rd_n |= (b == 3);
            h.program_store_enable_n |= (b == 4);
            h.ale &= (b != 5);
            #1;
            chk(array_strobes, h);
            at(1);
         end
      end
      wr(pgr_pkg::PGR_ADDR_STROBE, 8'h00);
      busy <= 1'b0;
      // Clock gated from the logic must still reach the idle counter
      idle_run(8'h32, 14, 1'b0);
      pulses(1);
      #1;
      chk(power_down_flag, 1'b1);
      chk(mem_bus | logic_bus, 8'h00);
      chk(mem.flash_en | mem.sram_en, 1'b0);
      at(1);
      busy <= 1'b1;
      at(2);
      busy <= 1'b0;
      at(2);
      #1;
      chk(power_down_flag, 1'b0);
      at(1);
      idle_run(8'h30, 16, 1'b0);
      idle_run(8'h02, 15, 1'b1);
      port_d_pin_two <= 1'b0;
      at(3);
      #1;
      chk(power_down_flag, 1'b0);
      at(1);
      wr(pgr_pkg::PGR_ADDR_STROBE, 8'h24);
      reset_n_pin <= 1'b0;
      at(1);
      reset_n_pin <= 1'b1;
      rd(pgr_pkg::PGR_ADDR_PRIMARY, 8'h00);
      #1;
      chk(in_reset, 1'b1);
      chk(logic_outputs_valid, 1'b1);
      chk(flash_read_cmd, 1'b1);
      ready();
      rd(pgr_pkg::PGR_ADDR_PRIMARY, 8'h02);
      rd(pgr_pkg::PGR_ADDR_STROBE, 8'h24);
      rst <= 1'b1;
      at(2);
      rst <= 1'b0;
      ready();
      rd(pgr_pkg::PGR_ADDR_PRIMARY, 8'h00);
      rd(pgr_pkg::PGR_ADDR_STROBE, 8'h00);
      at(2);
      finish_test();
   end

   // Whole run is well under two thousand cycles
   initial begin
      #100us;
      errors++;
      finish_test();
   end
endmodule

bind pgr_power_ctrl pgr_power_ctrl_chk #(.OPR_CYCLES(OPR_CYCLES), .BUS_WIDTH(BUS_WIDTH)) chk_u (
   .clock(clock), .rst(rst), .reset_n_pin(reset_n_pin), .port_d_pin_two(port_d_pin_two),
   .port_d_pin_one(port_d_pin_one), .host(host), .host_bus(host_bus), .mem(mem),
   .flash_read_cmd(flash_read_cmd), .mem_bus(mem_bus), .logic_bus(logic_bus),
   .logic_outputs_valid(logic_outputs_valid), .power_down_flag(power_down_flag),
   .in_reset(in_reset));
